// File: rtl/uasb_pkg.sv
package uasb_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  // shadow window: sixteen word locations, all reaching one buffer path
  localparam logic [31:0] SHADOW_BASE_ADDR = 32'h5000_1130;
  localparam logic [31:0] SHADOW_LAST_ADDR = 32'h5000_116C;
  localparam logic [31:0] SHADOW8_ADDR = 32'h5000_1150;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1200;
  localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h5000_1204;
  localparam logic [31:0] MODE_CONTROL_ADDR = 32'h5000_1208;
  localparam logic [31:0] INT_STATUS_ADDR = 32'h5000_120C;
  localparam logic [31:0] INT_MASK_ADDR = 32'h5000_1210;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LS_RX_DATA_READY_BIT = 0;
  localparam int LS_OVERRUN_BIT = 1;
  localparam int LS_TX_HOLDING_EMPTY_BIT = 5;
  localparam int FC_ENABLE_BIT = 0;
  localparam int MC_INFRARED_BIT = 0;
  localparam int INT_RX_BIT = 0;
  localparam int INT_OVERRUN_BIT = 1;
  localparam int INT_TX_EMPTY_BIT = 2;
  localparam int INT_W = 3;

  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [INT_W-1:0] INT_RESET = 3'h0;
  localparam int FIFO_DEPTH_DEFAULT = 16;

  // one byte moving on a stream, with its qualifier
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } uasb_byte_s;

  // one register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } uasb_bus_s;

endpackage

// File: rtl/uasb_shadow_buffer.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps

// Contract
// R1 - shadow read returns received byte, low eight
// R2 - read data valid only while ready flag
// R3 - no fifo: new byte overwrites, overrun flagged
// R4 - fifo on: shadow read pops receive head
// R5 - full receive fifo: drop new, flag overrun
// R6 - shadow write queues byte on serial/infrared
// R7 - master writes only while holding empty
// R8 - no fifo: single write clears holding empty
// R9 - no fifo: further writes overwrite pending byte
// R10 - fifo on: accept writes up to depth
// R11 - write into full transmit fifo discarded
// R12 - sixteen word aliases reach same buffer
// R13 - upper shadow bits read zero, writes ignored
module uasb_shadow_buffer #(
  parameter int RX_DEPTH = uasb_pkg::FIFO_DEPTH_DEFAULT,
  parameter int TX_DEPTH = uasb_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire uasb_pkg::uasb_bus_s busReq,
  output logic [uasb_pkg::DATA_W-1:0] busRdData,
  input wire uasb_pkg::uasb_byte_s serialRxByte,
  input wire uasb_pkg::uasb_byte_s irRxByte,
  output uasb_pkg::uasb_byte_s serialTxByte,
  output uasb_pkg::uasb_byte_s irTxByte,
  input wire logic txShifterReady,
  output logic irMode,
  output logic irq
);
  import uasb_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  localparam int RA_W = $clog2(RX_DEPTH);
  localparam int TA_W = $clog2(TX_DEPTH);
  localparam int RC_W = $clog2(RX_DEPTH + 1);
  localparam int TC_W = $clog2(TX_DEPTH + 1);

  // pointers wrap by overflow, so depths must be powers of two
  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : gRxDepthCheck
    $error("receive depth must be a power of two, at least 2");
  end
  if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : gTxDepthCheck
    $error("transmit depth must be a power of two, at least 2");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic fifoEn_reg;
  logic irMode_reg;
  logic [7:0] rxMem [RX_DEPTH];
  logic [RA_W-1:0] rxWrPtr_reg;
  logic [RA_W-1:0] rxRdPtr_reg;
  logic [RC_W-1:0] rxCount_reg;
  logic [7:0] rxHold_reg;
  logic rxHoldValid_reg;
  logic overrun_reg;
  logic [7:0] txMem [TX_DEPTH];
  logic [TA_W-1:0] txWrPtr_reg;
  logic [TA_W-1:0] txRdPtr_reg;
  logic [TC_W-1:0] txCount_reg;
  logic [7:0] txHold_reg;
  logic txHoldFull_reg;
  logic serTxValid_reg;
  logic irTxValid_reg;
  logic [7:0] txData_reg;
  logic [INT_W-1:0] intStatus_reg;
  logic [INT_W-1:0] intMask_reg;
  logic [DATA_W-1:0] busRdData_reg;
  logic irq_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic shadowHit;
  logic shadowRd;
  logic shadowWr;
  logic fifoCtrlWr;
  logic dataReady;
  logic txHoldingEmpty;
  uasb_byte_s rxIn;
  logic rxAccept;
  logic rxDrop;
  logic rxPop;
  logic txPush;
  logic txLoad;
  logic txSrcAvail;
  logic [7:0] txSrcData;

  // every word in the window decodes to the same buffer path
  assign shadowHit = (busReq.addr >= SHADOW_BASE_ADDR) &&
                     (busReq.addr <= SHADOW_LAST_ADDR) &&
                     (busReq.addr[1:0] == 2'h0); // R12
  assign shadowRd = busReq.rd && shadowHit;
  assign shadowWr = busReq.wr && shadowHit;
  assign fifoCtrlWr = busReq.wr && (busReq.addr == FIFO_CONTROL_ADDR);

  // ready flag and holding-empty flag as seen by software
  assign dataReady = fifoEn_reg ? (rxCount_reg != '0) : rxHoldValid_reg;
  assign txHoldingEmpty = fifoEn_reg ? (txCount_reg == '0) : !txHoldFull_reg;

  // receive source follows the line mode
  assign rxIn = irMode_reg ? irRxByte : serialRxByte; // R1
  assign rxPop = shadowRd && dataReady && fifoEn_reg; // R4
  // a pop in the same cycle frees the slot, so the byte is kept
  assign rxAccept = rxIn.valid &&
                    ((rxCount_reg < RC_W'(RX_DEPTH)) || rxPop); // R5
  assign rxDrop = rxIn.valid && (fifoEn_reg ? !rxAccept : rxHoldValid_reg);

  // transmit side: writes beyond depth never reach the array
  assign txPush = shadowWr && fifoEn_reg &&
                  (txCount_reg < TC_W'(TX_DEPTH)); // R10 R11
  assign txSrcAvail = fifoEn_reg ? (txCount_reg != '0) : txHoldFull_reg;
  assign txSrcData = fifoEn_reg ? txMem[txRdPtr_reg] : txHold_reg;
  assign txLoad = txSrcAvail && !fifoCtrlWr &&
                  (!(serTxValid_reg || irTxValid_reg) || txShifterReady);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // a fifo control write flushes both paths; a mode change flushes neither
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifoEn_reg <= 1'b0;
      irMode_reg <= 1'b0;
      intMask_reg <= INT_RESET;
    end else begin
      if (fifoCtrlWr) begin
        fifoEn_reg <= busReq.wrData[FC_ENABLE_BIT];
      end
      if (busReq.wr && busReq.addr == MODE_CONTROL_ADDR) begin
        irMode_reg <= busReq.wrData[MC_INFRARED_BIT];
      end
      if (busReq.wr && busReq.addr == INT_MASK_ADDR) begin
        intMask_reg <= busReq.wrData[INT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  // fifo storage has no reset; only pointers and count carry state
  always_ff @(posedge ref_clk) begin
    if (fifoEn_reg && rxAccept) begin
      rxMem[rxWrPtr_reg] <= rxIn.data;
    end
  end

  // pointers, count and the single holding byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxWrPtr_reg <= '0;
      rxRdPtr_reg <= '0;
      rxCount_reg <= '0;
      rxHold_reg <= BYTE_RESET;
      rxHoldValid_reg <= 1'b0;
    end else if (fifoCtrlWr) begin
      rxWrPtr_reg <= '0;
      rxRdPtr_reg <= '0;
      rxCount_reg <= '0;
      rxHoldValid_reg <= 1'b0;
    end else if (fifoEn_reg) begin
      if (rxAccept) begin
        rxWrPtr_reg <= rxWrPtr_reg + RA_W'(1);
      end
      if (rxPop) begin
        rxRdPtr_reg <= rxRdPtr_reg + RA_W'(1); // R4
      end
      if (rxAccept && !rxPop) begin
        rxCount_reg <= rxCount_reg + RC_W'(1);
      end else if (!rxAccept && rxPop) begin
        rxCount_reg <= rxCount_reg - RC_W'(1);
      end
    end else begin
      // an arrival overwrites an unread byte; arrival wins over a read
      if (rxIn.valid) begin
        rxHold_reg <= rxIn.data; // R3
        rxHoldValid_reg <= 1'b1;
      end else if (shadowRd) begin
        rxHoldValid_reg <= 1'b0;
      end
    end
  end

  // overrun flag: cleared by a line status read, but a new loss wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (rxDrop) begin
      overrun_reg <= 1'b1; // R3 R5
    end else if (busReq.rd && busReq.addr == LINE_STATUS_ADDR) begin
      overrun_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  // only the low byte of a shadow write is kept
  always_ff @(posedge ref_clk) begin
    if (txPush) begin
      txMem[txWrPtr_reg] <= busReq.wrData[7:0]; // R6 R13
    end
  end

  // queue bookkeeping and the single holding byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txWrPtr_reg <= '0;
      txRdPtr_reg <= '0;
      txCount_reg <= '0;
      txHold_reg <= BYTE_RESET;
      txHoldFull_reg <= 1'b0;
    end else if (fifoCtrlWr) begin
      txWrPtr_reg <= '0;
      txRdPtr_reg <= '0;
      txCount_reg <= '0;
      txHoldFull_reg <= 1'b0;
    end else if (fifoEn_reg) begin
      if (txPush) begin
        txWrPtr_reg <= txWrPtr_reg + TA_W'(1); // R10
      end
      if (txLoad) begin
        txRdPtr_reg <= txRdPtr_reg + TA_W'(1);
      end
      if (txPush && !txLoad) begin
        txCount_reg <= txCount_reg + TC_W'(1);
      end else if (!txPush && txLoad) begin
        txCount_reg <= txCount_reg - TC_W'(1);
      end
    end else begin
      // a write always lands; one still pending is overwritten
      if (shadowWr) begin
        txHold_reg <= busReq.wrData[7:0]; // R9 R13
        txHoldFull_reg <= 1'b1; // R8
      end else if (txLoad) begin
        txHoldFull_reg <= 1'b0;
      end
    end
  end

  // byte offered to one shifter; one valid per path keeps outputs on flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serTxValid_reg <= 1'b0;
      irTxValid_reg <= 1'b0;
      txData_reg <= BYTE_RESET;
    end else if (txLoad) begin
      serTxValid_reg <= !irMode_reg; // R6
      irTxValid_reg <= irMode_reg; // R6
      txData_reg <= txSrcData;
    end else if (txShifterReady) begin
      serTxValid_reg <= 1'b0;
      irTxValid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic [INT_W-1:0] intEvents;
  logic txEmptyPrev_reg;

  assign intEvents[INT_RX_BIT] = rxIn.valid && (!fifoEn_reg || rxAccept); // overwrite still stores
  assign intEvents[INT_OVERRUN_BIT] = rxDrop;
  assign intEvents[INT_TX_EMPTY_BIT] = txHoldingEmpty && !txEmptyPrev_reg;

  // sticky status, cleared by its read; an event in that cycle survives
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      intStatus_reg <= INT_RESET;
      txEmptyPrev_reg <= 1'b1;
    end else begin
      txEmptyPrev_reg <= txHoldingEmpty;
      if (busReq.rd && busReq.addr == INT_STATUS_ADDR) begin
        intStatus_reg <= intEvents;
      end else begin
        intStatus_reg <= intStatus_reg | intEvents;
      end
    end
  end

  // level output, one cycle behind the status it reflects
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(intStatus_reg & intMask_reg);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // data stand one cycle after the strobe and only then; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busRdData_reg <= '0;
    end else begin
      busRdData_reg <= '0;
      if (shadowRd) begin
        // stale data is not promised; software checks the ready flag
        busRdData_reg[7:0] <= fifoEn_reg ? rxMem[rxRdPtr_reg] : rxHold_reg; // R1 R2 R13
      end else if (busReq.rd) begin
        case (busReq.addr)
          LINE_STATUS_ADDR: begin
            busRdData_reg[LS_RX_DATA_READY_BIT] <= dataReady; // R2
            busRdData_reg[LS_OVERRUN_BIT] <= overrun_reg;
            busRdData_reg[LS_TX_HOLDING_EMPTY_BIT] <= txHoldingEmpty; // R7
          end
          FIFO_CONTROL_ADDR: busRdData_reg[FC_ENABLE_BIT] <= fifoEn_reg;
          MODE_CONTROL_ADDR: busRdData_reg[MC_INFRARED_BIT] <= irMode_reg;
          INT_STATUS_ADDR: busRdData_reg[INT_W-1:0] <= intStatus_reg;
          INT_MASK_ADDR: busRdData_reg[INT_W-1:0] <= intMask_reg;
          default: busRdData_reg <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign busRdData = busRdData_reg;
  assign serialTxByte.valid = serTxValid_reg;
  assign serialTxByte.data = txData_reg;
  assign irTxByte.valid = irTxValid_reg;
  assign irTxByte.data = txData_reg;
  assign irMode = irMode_reg;
  assign irq = irq_reg;

endmodule

// File: sim/uasb_shadow_buffer_asserts.sv
`timescale 1ns/1ps

// ------
// port checker for the shadow buffer
// ------
module uasb_shadow_asserts
  import uasb_pkg::*;
#(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire uasb_pkg::uasb_bus_s busReq,
  input wire logic [uasb_pkg::DATA_W-1:0] busRdData,
  input wire uasb_pkg::uasb_byte_s serialRxByte,
  input wire uasb_pkg::uasb_byte_s irRxByte,
  input wire uasb_pkg::uasb_byte_s serialTxByte,
  input wire uasb_pkg::uasb_byte_s irTxByte,
  input wire logic txShifterReady,
  input wire logic irMode,
  input wire logic irq
);
  logic inWin, shadowWr, rdShadow, modeWr, fcWr, anyTx;
  logic [INT_W-1:0] maskReg;

  // decode of the requests the checker cares about
  assign inWin = busReq.addr >= SHADOW_BASE_ADDR && busReq.addr <= SHADOW_LAST_ADDR;
  assign shadowWr = busReq.wr && inWin;
  assign rdShadow = busReq.rd && inWin;
  assign modeWr = busReq.wr && busReq.addr == MODE_CONTROL_ADDR;
  assign fcWr = busReq.wr && busReq.addr == FIFO_CONTROL_ADDR;
  assign anyTx = serialTxByte.valid || irTxByte.valid;

  // shadow copy of the mask, so irq can be judged without peeking inside
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      maskReg <= INT_RESET;
    end else if (busReq.wr && busReq.addr == INT_MASK_ADDR) begin
      maskReg <= busReq.wrData[INT_W-1:0];
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence sOffer;
    ##[1:2] anyTx;
  endsequence

  sequence sHeld;
    serialTxByte.valid && $stable(serialTxByte.data);
  endsequence

  chk_rd_idle: assert property (!$past(busReq.rd) |-> busRdData == '0)
    else $error("read data not zero outside a read answer");
  chk_upper_zero: assert property ($past(rdShadow) |-> busRdData[31:8] == '0)
    else $error("shadow read upper bits not zero");
  chk_write_offers: assert property (shadowWr && !anyTx |-> sOffer)
    else $error("shadow write not offered to the shifter");
  chk_tx_hold: assert property (serialTxByte.valid && !txShifterReady && !fcWr |=> sHeld)
    else $error("offered byte dropped or changed before acceptance");
  chk_one_path: assert property (!(serialTxByte.valid && irTxByte.valid))
    else $error("both transmit paths offered at once");
  chk_rx_irq: assert property (
    serialRxByte.valid && !irMode && maskReg[INT_RX_BIT] |-> ##[1:2] irq)
    else $error("unmasked receive event gave no interrupt");
  chk_mask_quiet: assert property ($past(maskReg) == '0 |-> !irq)
    else $error("interrupt high with all sources masked");
  chk_mode_steady: assert property (!$past(modeWr) && !$past(modeWr, 2) |-> $stable(irMode))
    else $error("mode output moved without a mode write");
endmodule

bind uasb_shadow_buffer uasb_shadow_asserts #(.RX_DEPTH(RX_DEPTH), .TX_DEPTH(TX_DEPTH)) chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .busReq(busReq),
  .busRdData(busRdData),
  .serialRxByte(serialRxByte),
  .irRxByte(irRxByte),
  .serialTxByte(serialTxByte),
  .irTxByte(irTxByte),
  .txShifterReady(txShifterReady),
  .irMode(irMode),
  .irq(irq)
);

// File: sim/uasb_peer.sv
`timescale 1ns/1ps

// ------
// far side: deserialisers that deliver bytes, shifters that take them
// ------
module uasb_peer
  import uasb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stallTx,
  input wire uasb_pkg::uasb_byte_s serialTxByte,
  input wire uasb_pkg::uasb_byte_s irTxByte,
  output uasb_pkg::uasb_byte_s serialRxByte,
  output uasb_pkg::uasb_byte_s irRxByte,
  output logic txShifterReady
);
  logic [8:0] txSeen[$];

  initial begin
    serialRxByte = '{1'b0, 8'h00};
    irRxByte = '{1'b0, 8'h00};
    txShifterReady = 1'b0;
  end

  // shifter accepts unless stalled; a stall stands for a slow line
  always @(posedge ref_clk) begin
    txShifterReady <= rst_n && !stallTx;
    if (txShifterReady && serialTxByte.valid) begin
      txSeen.push_back({1'b0, serialTxByte.data});
    end
    if (txShifterReady && irTxByte.valid) begin
      txSeen.push_back({1'b1, irTxByte.data});
    end
  end

  // one received byte; idle data is inverted so stale values never match
  task automatic send_byte(input logic ir, input logic [7:0] d);
    @(posedge ref_clk);
    serialRxByte <= '{!ir, ir ? ~d : d};
    irRxByte <= '{ir, ir ? d : ~d};
    @(posedge ref_clk);
    serialRxByte <= '{1'b0, ~d};
    irRxByte <= '{1'b0, ~d};
  endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import uasb_pkg::*;
  localparam int DEPTH = 4;
  logic ref_clk = 1'b0;
  logic rst_n, stallTx, txShifterReady, irMode, irq;
  uasb_bus_s busReq;
  logic [DATA_W-1:0] busRdData;
  uasb_byte_s serialRxByte, irRxByte, serialTxByte, irTxByte;
  logic [8:0] expTx[$];
  int num_errors = 0;
  int samples_checked = 0;

  // ------
  // clock, design and far side
  // ------
  always #4 ref_clk = ~ref_clk;

  uasb_shadow_buffer #(.RX_DEPTH(DEPTH), .TX_DEPTH(DEPTH)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .busRdData(busRdData),
    .serialRxByte(serialRxByte), .irRxByte(irRxByte), .serialTxByte(serialTxByte),
    .irTxByte(irTxByte), .txShifterReady(txShifterReady), .irMode(irMode), .irq(irq));

  uasb_peer peer (
    .ref_clk(ref_clk), .rst_n(rst_n), .stallTx(stallTx), .serialTxByte(serialTxByte),
    .irTxByte(irTxByte), .serialRxByte(serialRxByte), .irRxByte(irRxByte),
    .txShifterReady(txShifterReady));

  // ------
  // access tasks
  // ------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    busReq <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    busReq <= '{1'b0, 1'b0, a, d};
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input bit cmp = 1'b1);
    @(posedge ref_clk);
    busReq <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk);
    busReq <= '{1'b0, 1'b0, a, 32'h0};
    #1;
    if (cmp) check(busRdData, e);
  endtask

  // bounded wait for the shifter side, then compare what it took
  task automatic tx_drain();
    for (int i = 0; i < 200 && peer.txSeen.size() < expTx.size(); i++) @(posedge ref_clk);
    check(32'(peer.txSeen.size()), 32'(expTx.size()));
    foreach (expTx[i]) check(32'(peer.txSeen[i]), 32'(expTx[i]));
    peer.txSeen.delete();
    expTx.delete();
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #(8 * 20000);
    num_errors++;
    complete_run();
  end

  // ------
  // tests
  // ------
  initial begin
    busReq = '0;
    stallTx = 1'b0;
    rst_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0020);
    rd_chk(INT_STATUS_ADDR, 32'h0000_0000);
    rd_chk(SHADOW_LAST_ADDR + 32'h4, 32'h0000_0000);
    $display("test reset done");
    peer.send_byte(1'b0, 8'h5A);
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0021);
    peer.send_byte(1'b0, 8'h3C);
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0023);
    rd_chk(SHADOW8_ADDR, 32'h0000_003C);
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0020);
    $display("test rx plain done");
    stallTx <= 1'b1;
    bus_wr(SHADOW8_ADDR, 32'hFFFF_FF11);
    repeat (3) @(posedge ref_clk);
    bus_wr(SHADOW_BASE_ADDR, 32'h0000_0022);
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0000);
    bus_wr(SHADOW_LAST_ADDR, 32'h0000_0033);
    expTx = '{9'h011, 9'h033};
    stallTx <= 1'b0;
    tx_drain();
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0020);
    $display("test tx plain done");
    bus_wr(FIFO_CONTROL_ADDR, 32'h0000_0001);
    stallTx <= 1'b1;
    bus_wr(SHADOW8_ADDR, 32'h0000_00A0);
    repeat (3) @(posedge ref_clk);
    for (int i = 1; i <= DEPTH + 1; i++) bus_wr(SHADOW_BASE_ADDR + 32'(4 * i), 32'(8'hA0 + i));
    for (int i = 0; i <= DEPTH; i++) expTx.push_back(9'(8'hA0 + i));
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0000);
    stallTx <= 1'b0;
    tx_drain();
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0020);
    $display("test tx queue done");
    for (int i = 0; i <= DEPTH; i++) peer.send_byte(1'b0, 8'(8'hB0 + i));
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0023);
    for (int i = 0; i < DEPTH; i++) rd_chk(SHADOW_BASE_ADDR + 32'(8 * i), 32'(8'hB0 + i));
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0020);
    $display("test rx queue done");
    bus_wr(FIFO_CONTROL_ADDR, 32'h0000_0000);
    bus_wr(MODE_CONTROL_ADDR, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    check(32'(irMode), 32'h0000_0001);
    peer.send_byte(1'b0, 8'h99);
    peer.send_byte(1'b1, 8'h6E);
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0021);
    rd_chk(SHADOW8_ADDR, 32'h0000_006E);
    rd_chk(LINE_STATUS_ADDR, 32'h0000_0020);
    expTx = '{9'h147};
    bus_wr(SHADOW8_ADDR, 32'h0000_0047);
    tx_drain();
    bus_wr(MODE_CONTROL_ADDR, 32'h0000_0000);
    $display("test infrared done");
    rd_chk(INT_STATUS_ADDR, 32'h0, 1'b0);
    bus_wr(INT_MASK_ADDR, 32'h0000_0001);
    peer.send_byte(1'b0, 8'h5C);
    repeat (2) @(posedge ref_clk);
    #1;
    check(32'(irq), 32'h0000_0001);
    rd_chk(INT_STATUS_ADDR, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    #1;
    check(32'(irq), 32'h0000_0000);
    bus_wr(INT_MASK_ADDR, 32'h0000_0000);
    peer.send_byte(1'b0, 8'h5D);
    repeat (3) @(posedge ref_clk);
    #1;
    check(32'(irq), 32'h0000_0000);
    $display("test interrupt done");
    complete_run();
  end
endmodule
